/* File: rtl/afim_pkg.sv */
// afim_pkg: register map, reset values and field positions of the fault
// interrupt mask block.
// assumes one system clock and an 8-bit internal register port.
`default_nettype none
package afim_pkg;
   localparam logic [7:0] ADDR_MISC_CONFIG  = 8'h2d;
   localparam logic [7:0] ADDR_MASK_CLK_BST = 8'h2f;
   localparam logic [7:0] ADDR_MASK_CHAN_DC = 8'h30;
   localparam logic [7:0] ADDR_MASK_IN_DIAG = 8'h31;
   localparam logic [7:0] ADDR_MASK_IN_OV   = 8'h32;
   localparam logic [7:0] ADDR_LATCHED_EVT  = 8'h34;

   localparam logic [7:0] RST_MISC_CONFIG  = 8'h00;
   localparam logic [7:0] RST_MASK_CLK_BST = 8'hff;
   localparam logic [7:0] RST_MASK_CHAN_DC = 8'h0f;
   localparam logic [7:0] RST_MASK_IN_DIAG = 8'h00;
   localparam logic [7:0] RST_MASK_IN_OV   = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

   // field positions
   localparam int BIT_COMPRESSOR_EN  = 4;
   localparam int BIT_MONITOR_SEL    = 1;
   localparam int BIT_CLK_ERR        = 7;
   localparam int BIT_PLL_LOCK       = 6;
   localparam int BIT_BOOST_OT       = 5;
   localparam int BIT_BOOST_OC       = 4;
   localparam int BIT_BOOST_MISC     = 3;
   localparam int BIT_SHORT_BAT_LOW  = 3;
   localparam int CLK_BST_HI         = 7;
   localparam int CLK_BST_LO         = 3;
   localparam int CHAN_DC_HI         = 7;
   localparam int CHAN_DC_LO         = 4;
   localparam int OV_HI              = 7;
   localparam int OV_LO              = 6;

   localparam int N_CLK_BST_EVT = 5;
   localparam logic [2:0] STATUS_RSVD = 3'h0;
endpackage
`default_nettype wire

/* File: rtl/afim_evt_if.sv */
// afim_evt_if: event pulses, read-clear strobe and latched status between
// the register block and its self-clearing status latch.
// assumes both ends share sys_clk.
`timescale 1ns/100ps
`default_nettype none
interface afim_evt_if;
   logic [4:0] evt;
   logic       readClear;
   logic [4:0] status;
   modport latch (input evt, input readClear, output status);
   modport ctrl  (output evt, output readClear, input status);
endinterface
`default_nettype wire

/* File: rtl/afim_status_latch.sv */
// afim_status_latch: sticky clock, pll and boost event flags, cleared by a
// read of the latched status register.
// assumes event pulses and the read strobe are on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module afim_status_latch
   import afim_pkg::*;
(
   input  wire logic    sys_clk,
   input  wire logic    rstn,
   afim_evt_if.latch    evtBus
);

   genvar gi;
   generate
      for (gi = 0; gi < N_CLK_BST_EVT; gi++)
      begin : g_flag
         // an event in the clearing cycle survives the read
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
               evtBus.status[gi] <= 1'b0;
            else if (evtBus.evt[gi])
               evtBus.status[gi] <= 1'b1;
            else if (evtBus.readClear)
               evtBus.status[gi] <= 1'b0;
         end
      end
   endgenerate

endmodule // afim_status_latch
`default_nettype wire

/* File: rtl/afim_fault_mask.sv */
// afim_fault_mask: interrupt mask registers, miscellaneous configuration and
// latched clock/boost status of an audio converter, with the interrupt output.
// assumes a same-clock register port from the control-interface decoder and
// fault inputs from same-clock detectors; other fault inputs are levels.
`timescale 1ns/100ps
`default_nettype none
module afim_fault_mask
   import afim_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic [7:0] regAddr,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   input  wire logic [7:0] regWdata,
   output logic      [7:0] regRdata,
   input  wire logic       clkErrEvt,
   input  wire logic       pllLockEvt,
   input  wire logic       boostOverTempEvt,
   input  wire logic       boostOverCurrEvt,
   input  wire logic       boostMiscFaultEvt,
   input  wire logic [3:0] chanDcFault,
   input  wire logic       shortBatLowFault,
   input  wire logic [7:0] inputDiagFault,
   input  wire logic [1:0] overvoltFault,
   output logic            irq,
   output logic            compressorEnable,
   output logic            monitorSourceSelect
);

   logic [7:0] miscConfig;
   logic [7:0] maskClkBoost;
   logic [7:0] maskChanDc;
   logic [7:0] maskInDiag;
   logic [7:0] maskInOv;
   logic [7:0] latchedStatus;
   logic [7:0] next_rdata;
   logic       next_irq;

   afim_evt_if evtBus ();

   // a set mask bit blocks its source
   function automatic logic anyUnmasked(input logic [7:0] src, input logic [7:0] msk);
      anyUnmasked = |(src & ~msk);
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic en);
      hit = en && (a == b);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // latched clock and boost events

   assign evtBus.evt = {clkErrEvt, pllLockEvt, boostOverTempEvt, boostOverCurrEvt,
                        boostMiscFaultEvt};
   assign evtBus.readClear = hit(regAddr, ADDR_LATCHED_EVT, regRead);
   assign latchedStatus = {evtBus.status, STATUS_RSVD};

   afim_status_latch u_latch (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .evtBus  (evtBus)
   );

   ////////////////////////////////////////////////////////////////////////////
   // writable registers; reserved bits are stored as written

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         miscConfig <= RST_MISC_CONFIG;
      else if (hit(regAddr, ADDR_MISC_CONFIG, regWrite))
         miscConfig <= regWdata;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         maskClkBoost <= RST_MASK_CLK_BST;
      else if (hit(regAddr, ADDR_MASK_CLK_BST, regWrite))
         maskClkBoost <= regWdata;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         maskChanDc <= RST_MASK_CHAN_DC;
      else if (hit(regAddr, ADDR_MASK_CHAN_DC, regWrite))
         maskChanDc <= regWdata;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         maskInDiag <= RST_MASK_IN_DIAG;
      else if (hit(regAddr, ADDR_MASK_IN_DIAG, regWrite))
         maskInDiag <= regWdata;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         maskInOv <= RST_MASK_IN_OV;
      else if (hit(regAddr, ADDR_MASK_IN_OV, regWrite))
         maskInOv <= regWdata;
   end

   assign compressorEnable    = miscConfig[BIT_COMPRESSOR_EN];
   assign monitorSourceSelect = miscConfig[BIT_MONITOR_SEL];

   ////////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the read strobe

   always_comb
   begin
      case (regAddr)
         ADDR_MISC_CONFIG:  next_rdata = miscConfig;
         ADDR_MASK_CLK_BST: next_rdata = maskClkBoost;
         ADDR_MASK_CHAN_DC: next_rdata = maskChanDc;
         ADDR_MASK_IN_DIAG: next_rdata = maskInDiag;
         ADDR_MASK_IN_OV:   next_rdata = maskInOv;
         ADDR_LATCHED_EVT:  next_rdata = latchedStatus;
         default:           next_rdata = RDATA_UNMAPPED;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         regRdata <= RDATA_UNMAPPED;
      else if (regRead)
         regRdata <= next_rdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt: status stays recorded whatever the mask says

   always_comb
   begin
      next_irq = anyUnmasked(latchedStatus, maskClkBoost)
         || anyUnmasked({chanDcFault, shortBatLowFault, STATUS_RSVD}, maskChanDc)
         || anyUnmasked(inputDiagFault, maskInDiag)
         || anyUnmasked({overvoltFault, {OV_LO{1'b0}}}, maskInOv);
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         irq <= 1'b0;
      else
         irq <= next_irq;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // written from the mask fields, not from the interrupt expression itself
   property p_irq_cause;
      !(|(latchedStatus & ~maskClkBoost)
        || |({chanDcFault, shortBatLowFault} & ~maskChanDc[CHAN_DC_HI:BIT_SHORT_BAT_LOW])
        || |(inputDiagFault & ~maskInDiag)
        || |(overvoltFault & ~maskInOv[OV_HI:OV_LO])) |=> !irq;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without unmasked source");

   property p_clk_mask_write;
      hit(regAddr, ADDR_MASK_CLK_BST, regWrite) |=>
         maskClkBoost[CLK_BST_HI:CLK_BST_LO] == $past(regWdata[CLK_BST_HI:CLK_BST_LO]);
   endproperty
   a_clk_mask_write: assert property (p_clk_mask_write) else $error("clock mask not stored");

   property p_masked_event_quiet;
      (&maskClkBoost[CLK_BST_HI:CLK_BST_LO] && &maskChanDc[CHAN_DC_HI:BIT_SHORT_BAT_LOW]
       && &maskInDiag && &maskInOv[OV_HI:OV_LO] && !regWrite) [*2] |-> !irq;
   endproperty
   a_masked_event_quiet: assert property (p_masked_event_quiet) else $error("masked irq seen");

   property p_chan_read;
      hit(regAddr, ADDR_MASK_CHAN_DC, regRead) && !regWrite |=> regRdata == maskChanDc;
   endproperty
   a_chan_read: assert property (p_chan_read) else $error("channel mask readback wrong");

   property p_ov_unmasked;
      |(overvoltFault & ~maskInOv[OV_HI:OV_LO]) |=> irq;
   endproperty
   a_ov_unmasked: assert property (p_ov_unmasked) else $error("overvoltage irq missing");

   property p_diag_unmasked;
      |(inputDiagFault & ~maskInDiag) |=> irq;
   endproperty
   a_diag_unmasked: assert property (p_diag_unmasked) else $error("diag irq missing");

   property p_monitor_sel;
      hit(regAddr, ADDR_MISC_CONFIG, regWrite) |=>
         monitorSourceSelect == $past(regWdata[BIT_MONITOR_SEL]);
   endproperty
   a_monitor_sel: assert property (p_monitor_sel) else $error("monitor select wrong");

   property p_compressor;
      hit(regAddr, ADDR_MISC_CONFIG, regWrite) |=>
         compressorEnable == $past(regWdata[BIT_COMPRESSOR_EN]);
   endproperty
   a_compressor: assert property (p_compressor) else $error("compressor enable wrong");

   property p_event_latched;
      // the mask that counts is the one seen with the latched flag, a cycle back
      clkErrEvt |=> latchedStatus[BIT_CLK_ERR] ##1 (irq || $past(maskClkBoost[BIT_CLK_ERR]));
   endproperty
   a_event_latched: assert property (p_event_latched) else $error("clock error not latched");

   property p_read_clears;
      hit(regAddr, ADDR_LATCHED_EVT, regRead) && !(|evtBus.evt) |=>
         latchedStatus == 8'h00 && regRdata == $past(latchedStatus);
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("status not cleared by read");

   c_irq_from_boost: cover property (boostOverCurrEvt && !maskClkBoost[BIT_BOOST_OC] ##2 irq);
   c_set_over_clear: cover property (evtBus.readClear && pllLockEvt);
   c_compressor_on:  cover property ($rose(compressorEnable));
   c_chan_irq:       cover property (chanDcFault[3] && !maskChanDc[CHAN_DC_HI] ##1 irq);

endmodule // afim_fault_mask
`default_nettype wire

/* File: tb/afim_host_model.sv */
// afim_host_model: host side of the register port, one-cycle strobes only.
// assumes sys_clk from the bench; driven solely through its tasks.
`timescale 1ns/100ps
`default_nettype none
module afim_host_model
(
   input  wire logic       sys_clk,
   output logic      [7:0] regAddr,
   output logic            regWrite,
   output logic            regRead,
   output logic      [7:0] regWdata
);
   initial
   begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWdata = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // reserved bits forced to reset values, since the block stores them as given
   function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
      case (a)
         8'h2d: legal = d & 8'h12;
         8'h2f, 8'h30: legal = d | 8'h07;
         8'h32: legal = d & 8'hc0;
         default: legal = d;
      endcase
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= legal(a, d);
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
   endtask
endmodule // afim_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// tb_top: self-checking bench for the fault interrupt mask block.
// assumes the host model drives the register port; faults come from here.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import afim_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  regAddr;
   logic        regWrite;
   logic        regRead;
   logic [7:0]  regWdata;
   logic [7:0]  regRdata;
   logic        irq;
   logic        compressorEnable;
   logic        monitorSourceSelect;
   logic [19:0] faultVec = 20'h0;
   logic [7:0]  expQ[$];
   logic [7:0]  a;
   logic [7:0]  d;
   int          b;
   int          errTotal = 0;
   int          checked = 0;

   always #10 sys_clk = ~sys_clk;

   afim_host_model u_afim_host_model (.sys_clk(sys_clk), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata));

   afim_fault_mask u_afim_fault_mask (.sys_clk(sys_clk), .rstn(rstn),
      .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWdata(regWdata), .regRdata(regRdata), .clkErrEvt(faultVec[19]),
      .pllLockEvt(faultVec[18]), .boostOverTempEvt(faultVec[17]),
      .boostOverCurrEvt(faultVec[16]), .boostMiscFaultEvt(faultVec[15]),
      .chanDcFault(faultVec[14:11]), .shortBatLowFault(faultVec[10]),
      .inputDiagFault(faultVec[9:2]), .overvoltFault(faultVec[1:0]),
      .irq(irq), .compressorEnable(compressorEnable),
      .monitorSourceSelect(monitorSourceSelect));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         errTotal++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdx(input logic [7:0] ad, input logic [7:0] exp);
      expQ.push_back(exp);
      u_afim_host_model.rd(ad);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // read data is registered, so it is compared just after the taking edge
   always @(posedge sys_clk)
   begin
      if (regRead === 1'b1)
      begin
         #1;
         chk(regRdata, expQ.pop_front());
      end
   end

   initial
   begin
      #200000;
      errTotal++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(78566));
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      rdx(8'h2d, 8'h00);
      rdx(8'h2f, 8'hff);
      rdx(8'h30, 8'h0f);
      rdx(8'h31, 8'h00);
      rdx(8'h32, 8'h00);
      rdx(8'h34, 8'h00);
      for (int n = 0; n < 12; n++)
      begin
         a = 8'h2d + 8'(n % 6);
         d = u_afim_host_model.legal(a, 8'($urandom));
         u_afim_host_model.wr(a, d);
         rdx(a, (a == 8'h2e) ? 8'h00 : d);
         if (a == 8'h2d)
         begin
            chk({7'h0, compressorEnable}, {7'h0, d[4]});
            chk({7'h0, monitorSourceSelect}, {7'h0, d[1]});
         end
      end
      u_afim_host_model.wr(8'h34, 8'hff);
      rdx(8'h34, 8'h00);
      for (int m = 0; m < 4; m++)
         u_afim_host_model.wr(8'h2f + 8'(m), 8'hff);
      // one source at a time: blocked, then let through, then cleared
      for (int k = 19; k >= 0; k--)
      begin
         a = (k >= 15) ? 8'h2f : (k >= 10) ? 8'h30 : (k >= 2) ? 8'h31 : 8'h32;
         b = (k >= 15) ? k - 12 : (k >= 10) ? k - 7 : (k >= 2) ? k - 2 : k + 6;
         @(posedge sys_clk);
         faultVec <= 20'h1 << k;
         repeat (3) @(posedge sys_clk);
         #1 chk({7'h0, irq}, 8'h00);
         u_afim_host_model.wr(a, ~(8'h01 << b));
         repeat (2) @(posedge sys_clk);
         #1 chk({7'h0, irq}, 8'h01);
         u_afim_host_model.wr(a, 8'hff);
         // event still high across this read, so its flag must survive the clear
         if (k >= 15)
            rdx(8'h34, 8'h01 << b);
         @(posedge sys_clk);
         faultVec <= 20'h0;
         if (k >= 15)
            rdx(8'h34, 8'h01 << b);
         rdx(8'h34, 8'h00);
         repeat (2) @(posedge sys_clk);
         #1 chk({7'h0, irq}, 8'h00);
      end
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      rdx(8'h2f, 8'hff);
      rdx(8'h30, 8'h0f);
      rdx(8'h31, 8'h00);
      repeat (3) @(posedge sys_clk);
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
